/* File: pkg/vcpa_defs.svh */
// Purpose: Constants of the virtual pending query and alias ack block
// Assumes: AXI4-Lite, 32-bit data, 8-bit byte address
// Notes:   Offsets are byte addresses of aligned words
`ifndef VCPA_DEFS_SVH
`define VCPA_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define VCPA_A_HPP 8'h00
`define VCPA_A_ABP 8'h04
`define VCPA_A_AIA 8'h08
`define VCPA_A_CTL 8'h0C
`define VCPA_A_APR 8'h10
`define VCPA_A_STS 8'h14
`define VCPA_A_MSK 8'h18
`define VCPA_A_LE0 8'h20
`define VCPA_A_LE3 8'h2C

// ----------------------------------------
// Sizes and special identifiers
// ----------------------------------------
`define VCPA_NLE 4
`define VCPA_ID_SPUR 10'h3FF
`define VCPA_ID_G1 10'h3FE
`define VCPA_PRI_NONE 6'h20

// ----------------------------------------
// Query, acknowledge and binary point word fields
// ----------------------------------------
`define VCPA_ID_HI 9
`define VCPA_ID_LO 0
`define VCPA_CPU_HI 12
`define VCPA_CPU_LO 10
`define VCPA_RSV_LO 13
`define VCPA_BP_HI 2
`define VCPA_BP_RSV_LO 3

// ----------------------------------------
// List entry fields
// ----------------------------------------
`define VCPA_LE_PRI_HI 20
`define VCPA_LE_PRI_LO 16
`define VCPA_LE_ST_HI 29
`define VCPA_LE_ST_LO 28
`define VCPA_LE_GRP 30
`define VCPA_LE_HW 31

// ----------------------------------------
// Control, status, response
// ----------------------------------------
`define VCPA_CTL_ACK 0
`define VCPA_STS_ACK 0
`define VCPA_STS_SPUR 1
`define VCPA_STS_W 2
`define VCPA_RESP_OKAY 2'h0
`define VCPA_RESP_SLVERR 2'h2

`endif

/* File: pkg/vcpa_pkg.sv */
// Purpose: Types of the virtual pending query and alias ack block
// Assumes: Used with vcpa_defs.svh
// Notes:   None
package vcpa_pkg;

  // ----------------------------------------
  // List entry states
  // ----------------------------------------
  typedef enum logic [1:0] {
    VCPA_LE_INVALID = 2'b00,
    VCPA_LE_PEND = 2'b01,
    VCPA_LE_ACT = 2'b10,
    VCPA_LE_ACTPEND = 2'b11
  } vcpa_le_state_t;

endpackage

/* File: rtl/vcpa_top.sv */
// Purpose: Guest pending query and aliased acknowledge over AXI4-Lite
// Assumes: One clock, synchronous active-low reset, one read and one write
// Notes:   List entries and active priorities are software-writable here
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "vcpa_defs.svh"

// Function
// - Pending query returns top pending identifier, or 1023 if none.
// - Pending query never reports an active-and-pending entry.
// - Core field filled only when hardware flag of entry is 0.
// - Query and ack words: 31..13 reserved, 12..10 core, 9..0 id.
// - Group 0 top pending: query returns its id regardless of ack control.
// - Group 1 top pending: 1022 if ack control 0, real id if 1.
// - Query may return 1023 while pending interrupts sit outside entries.
// - Alias binary point: 3-bit field in 2..0, rest reserved.
// - Alias ack of group 0 entry returns 1023, no acknowledge.
// - Alias ack of group 1 returns id, plus core when hardware flag 0.
// - Successful alias ack makes entry active, sets active-priority bit.
// - No pending interrupt of sufficient priority: alias ack returns 1023.
// - Sufficiency judged as if interface and global enable were set.
module vcpa_top
  import vcpa_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address and data
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] merge_w(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [4:0] le_pri(input logic [31:0] e);
    return e[`VCPA_LE_PRI_HI:`VCPA_LE_PRI_LO];
  endfunction

  function automatic vcpa_le_state_t le_st(input logic [31:0] e);
    return vcpa_le_state_t'(e[`VCPA_LE_ST_HI:`VCPA_LE_ST_LO]);
  endfunction

  // Running priority: lowest set active bit, none gives 32
  function automatic logic [5:0] run_pri(input logic [31:0] a);
    logic [5:0] r;
    r = `VCPA_PRI_NONE;
    for (int i = 31; i >= 0; i--) begin
      if (a[i]) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction

  // Identifier word with core number only for software interrupts
  function automatic logic [31:0] id_word(input logic [31:0] e);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`VCPA_ID_HI:`VCPA_ID_LO] = e[`VCPA_ID_HI:`VCPA_ID_LO];
    if (!e[`VCPA_LE_HW]) begin
      w[`VCPA_CPU_HI:`VCPA_CPU_LO] = e[`VCPA_CPU_HI:`VCPA_CPU_LO];
    end
    return w;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic aw_rdy_r, aw_rdy_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic ar_rdy_r, ar_rdy_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] le_r [`VCPA_NLE];
  logic [31:0] le_nxt [`VCPA_NLE];
  logic [31:0] apr_r, apr_nxt;
  logic [2:0] bp_r, bp_nxt;
  logic ack_ctl_r, ack_ctl_nxt;
  logic [`VCPA_STS_W-1:0] sts_r, sts_nxt;
  logic [`VCPA_STS_W-1:0] msk_r, msk_nxt;
  logic irq_r, irq_nxt;

  logic wr_hs, rd_hs, is_hpp, is_aia;
  logic best_found, suff, aia_ok;
  logic [1:0] best_idx;
  logic [31:0] best_e, hpp_word, mrg;

  assign wr_hs = awvalid && wvalid && aw_rdy_r;
  assign rd_hs = arvalid && ar_rdy_r;
  assign is_hpp = araddr == `VCPA_A_HPP;
  assign is_aia = araddr == `VCPA_A_AIA;

  // ----------------------------------------
  // Pending selection
  // ----------------------------------------
  always_comb begin
    best_found = 1'b0;
    best_idx = 2'h0;
    for (int i = 0; i < `VCPA_NLE; i++) begin
      if (le_st(le_r[i]) == VCPA_LE_PEND &&
          (!best_found || le_pri(le_r[i]) < le_pri(le_r[best_idx]))) begin
        best_found = 1'b1;
        best_idx = 2'(i);
      end
    end
    best_e = le_r[best_idx];
    suff = {1'b0, le_pri(best_e)} < run_pri(apr_r);
    aia_ok = best_found && suff && best_e[`VCPA_LE_GRP];
    hpp_word = 32'h0000_0000;
    hpp_word[`VCPA_ID_HI:`VCPA_ID_LO] = `VCPA_ID_SPUR;
    if (best_found) begin
      if (best_e[`VCPA_LE_GRP] && !ack_ctl_r) begin
        hpp_word[`VCPA_ID_HI:`VCPA_ID_LO] = `VCPA_ID_G1;
      end else begin
        hpp_word = id_word(best_e);
      end
    end
  end

  // ----------------------------------------
  // Bus handshake next state
  // ----------------------------------------
  always_comb begin
    // Address and data are taken together, one write at a time
    aw_rdy_nxt = awvalid && wvalid && !aw_rdy_r && !bvalid_r;
    bvalid_nxt = wr_hs ? 1'b1 : (bready ? 1'b0 : bvalid_r);
    bresp_nxt = bresp_r;
    if (wr_hs) begin
      bresp_nxt = `VCPA_RESP_OKAY;
      if (awaddr[1:0] != 2'h0 || awaddr > `VCPA_A_LE3 ||
          (awaddr > `VCPA_A_MSK && awaddr < `VCPA_A_LE0)) begin
        bresp_nxt = `VCPA_RESP_SLVERR;
      end
    end
    ar_rdy_nxt = arvalid && !ar_rdy_r && !rvalid_r;
    rvalid_nxt = rd_hs ? 1'b1 : (rready ? 1'b0 : rvalid_r);
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (rd_hs) begin
      rresp_nxt = `VCPA_RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      unique case (araddr)
        `VCPA_A_HPP: rdata_nxt = hpp_word;
        `VCPA_A_ABP: rdata_nxt = {29'h0, bp_r};
        `VCPA_A_AIA: begin
          rdata_nxt[`VCPA_ID_HI:`VCPA_ID_LO] = `VCPA_ID_SPUR;
          if (aia_ok) begin
            rdata_nxt = id_word(best_e);
          end
        end
        `VCPA_A_CTL: rdata_nxt = {31'h0, ack_ctl_r};
        `VCPA_A_APR: rdata_nxt = apr_r;
        `VCPA_A_STS: rdata_nxt = {30'h0, sts_r};
        `VCPA_A_MSK: rdata_nxt = {30'h0, msk_r};
        default: begin
          if (araddr[1:0] == 2'h0 && araddr >= `VCPA_A_LE0 &&
              araddr <= `VCPA_A_LE3) begin
            rdata_nxt = le_r[araddr[3:2]];
          end else begin
            rresp_nxt = `VCPA_RESP_SLVERR;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Register file next state
  // ----------------------------------------
  always_comb begin
    le_nxt = le_r;
    apr_nxt = apr_r;
    bp_nxt = bp_r;
    ack_ctl_nxt = ack_ctl_r;
    msk_nxt = msk_r;
    sts_nxt = sts_r;
    mrg = 32'h0000_0000;
    if (wr_hs) begin
      unique case (awaddr)
        `VCPA_A_ABP: begin
          mrg = merge_w({29'h0, bp_r}, wdata, wstrb);
          bp_nxt = mrg[`VCPA_BP_HI:0];
        end
        `VCPA_A_CTL: begin
          mrg = merge_w({31'h0, ack_ctl_r}, wdata, wstrb);
          ack_ctl_nxt = mrg[`VCPA_CTL_ACK];
        end
        `VCPA_A_APR: apr_nxt = merge_w(apr_r, wdata, wstrb);
        `VCPA_A_MSK: begin
          mrg = merge_w({30'h0, msk_r}, wdata, wstrb);
          msk_nxt = mrg[`VCPA_STS_W-1:0];
        end
        default: begin
          if (awaddr[1:0] == 2'h0 && awaddr >= `VCPA_A_LE0 &&
              awaddr <= `VCPA_A_LE3) begin
            le_nxt[awaddr[3:2]] = merge_w(le_r[awaddr[3:2]], wdata, wstrb);
          end
        end
      endcase
    end
    // Status is read-to-clear; a new event in that cycle still lands
    if (rd_hs && araddr == `VCPA_A_STS) begin
      sts_nxt = '0;
    end
    if (rd_hs && is_aia) begin
      if (aia_ok) begin
        le_nxt[best_idx][`VCPA_LE_ST_HI:`VCPA_LE_ST_LO] = VCPA_LE_ACT;
        apr_nxt[le_pri(best_e)] = 1'b1;
        sts_nxt[`VCPA_STS_ACK] = 1'b1;
      end else begin
        sts_nxt[`VCPA_STS_SPUR] = 1'b1;
      end
    end
    irq_nxt = |(sts_nxt & msk_nxt);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_rdy_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `VCPA_RESP_OKAY;
      ar_rdy_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= `VCPA_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      for (int i = 0; i < `VCPA_NLE; i++) begin
        le_r[i] <= 32'h0000_0000;
      end
      apr_r <= 32'h0000_0000;
      bp_r <= 3'h0;
      ack_ctl_r <= 1'b0;
      sts_r <= '0;
      msk_r <= '0;
      irq_r <= 1'b0;
    end else begin
      aw_rdy_r <= aw_rdy_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      ar_rdy_r <= ar_rdy_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      le_r <= le_nxt;
      apr_r <= apr_nxt;
      bp_r <= bp_nxt;
      ack_ctl_r <= ack_ctl_nxt;
      sts_r <= sts_nxt;
      msk_r <= msk_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign awready = aw_rdy_r;
  assign wready = aw_rdy_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = ar_rdy_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign irq = irq_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_HPP_EMPTY: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_hs && is_hpp && !best_found |=>
      rdata_r[`VCPA_ID_HI:`VCPA_ID_LO] == `VCPA_ID_SPUR)
    else $error("empty query not spurious");
  AST_HPP_PEND: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_hs && is_hpp && best_found |->
      le_st(le_r[best_idx]) == VCPA_LE_PEND ##1 rvalid_r)
    else $error("query chose non-pending entry");
  AST_HPP_HWCPU: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_hs && is_hpp && best_found && best_e[`VCPA_LE_HW] |=>
      rdata_r[`VCPA_CPU_HI:`VCPA_CPU_LO] == 3'h0)
    else $error("core field set for hardware interrupt");
  AST_RSV_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_hs && (is_hpp || is_aia) |=> rdata_r[31:`VCPA_RSV_LO] == 19'h0)
    else $error("reserved bits not zero");
  AST_HPP_G0: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_hs && is_hpp && best_found && !best_e[`VCPA_LE_GRP] |=>
      rdata_r[`VCPA_ID_HI:`VCPA_ID_LO] == $past(best_e[`VCPA_ID_HI:0]))
    else $error("group 0 id wrong");
  AST_HPP_G1: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_hs && is_hpp && best_found && best_e[`VCPA_LE_GRP] && !ack_ctl_r
      |=> rdata_r[`VCPA_ID_HI:`VCPA_ID_LO] == `VCPA_ID_G1)
    else $error("group 1 not hidden");
  AST_ABP_RSV: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_hs && araddr == `VCPA_A_ABP |=>
      rdata_r[31:`VCPA_BP_RSV_LO] == 29'h0)
    else $error("binary point reserved bits set");
  AST_AIA_G0: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_hs && is_aia && best_found && suff && !best_e[`VCPA_LE_GRP] &&
      !wr_hs |=> rdata_r[`VCPA_ID_HI:`VCPA_ID_LO] == `VCPA_ID_SPUR &&
      $stable(apr_r))
    else $error("group 0 acknowledged");
  AST_AIA_CPU: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_hs && is_aia && aia_ok && !best_e[`VCPA_LE_HW] |=>
      rdata_r[`VCPA_CPU_HI:`VCPA_CPU_LO] == $past(best_e[12:10]))
    else $error("core number missing");
  AST_AIA_ACT: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_hs && is_aia && aia_ok |=> le_st(le_r[$past(best_idx)]) ==
      VCPA_LE_ACT && apr_r[$past(le_pri(best_e))])
    else $error("ack did not activate");
  AST_AIA_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_hs && is_aia && !(best_found && suff) |=>
      rdata_r[`VCPA_ID_HI:`VCPA_ID_LO] == `VCPA_ID_SPUR)
    else $error("insufficient priority acknowledged");
  AST_HPP_PURE: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_hs && is_hpp && !wr_hs |=> $stable(apr_r) && $stable(le_r[0]))
    else $error("query changed state");

endmodule

/* File: verification/vcpa_top_tb.sv */
// Purpose: Self-checking bench of the guest pending query and alias ack
// Assumes: AXI4-Lite master driven here, bready and rready held high
// Notes:   Bench keeps its own copy of entries, priorities and status
`timescale 1ns/1ps
`include "vcpa_defs.svh"

`define CHK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("wrong value at %0t: got %h exp %h", $time, (got), (exp)); \
  end \
end

module vcpa_top_tb;
  import vcpa_pkg::*;

  // ----------------------------------------
  // Signals and bench state
  // ----------------------------------------
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [31:0] le [4];
  logic [31:0] apr, q, e;
  logic [1:0] sts, msk, r;
  logic acknowledge_control;
  int n_fail, n_compared, cyc;

  vcpa_top vcpa_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .irq(irq));

  always #5 aclk = ~aclk;

  // Hang guard, well above the expected run length
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      final_report();
    end
  end

  // ----------------------------------------
  // Expectation functions
  // ----------------------------------------
  function automatic int best_idx();
    int b;
    b = -1;
    for (int i = 0; i < 4; i++)
      if (le[i][29:28] == 2'h1 && (b < 0 || le[i][20:16] < le[b][20:16]))
        b = i;
    return b;
  endfunction

  function automatic logic [31:0] id_word(input logic [31:0] x);
    return {19'h0, x[31] ? 3'h0 : x[12:10], x[9:0]};
  endfunction

  function automatic logic [31:0] exp_query();
    int b;
    b = best_idx();
    if (b < 0) return {22'h0, `VCPA_ID_SPUR};
    if (le[b][30] && !acknowledge_control) return {22'h0, `VCPA_ID_G1};
    return id_word(le[b]);
  endfunction

  function automatic logic [31:0] ack_model();
    int b, lo;
    b = best_idx();
    lo = 32;
    for (int k = 31; k >= 0; k--)
      if (apr[k]) lo = k;
    if (b < 0 || int'(le[b][20:16]) >= lo || !le[b][30]) begin
      sts[1] = 1'b1;
      return {22'h0, `VCPA_ID_SPUR};
    end
    le[b][29:28] = 2'h2;
    apr[le[b][20:16]] = 1'b1;
    sts[0] = 1'b1;
    return id_word(le[b]);
  endfunction

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] rs);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // Ready is a flop: look between edges, where it has settled
    do @(negedge aclk); while (awready !== 1'b1);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
    @(posedge aclk);
  endtask

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] rs;
    wr(a, d, 4'hF, rs);
    `CHK(rs, `VCPA_RESP_OKAY)
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] d;
    logic [1:0] rs;
    rd(a, d, rs);
    `CHK(d, x)
    `CHK(rs, `VCPA_RESP_OKAY)
  endtask

  task automatic final_report();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid} = 3'h0;
    {bready, rready} = 2'h3;
    {awprot, arprot} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    {n_fail, n_compared, cyc} = 0;
    {apr, acknowledge_control, sts, msk} = 37'h0;
    for (int i = 0; i < 4; i++)
      le[i] = 32'h0;
    void'($urandom(25559));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rd(`VCPA_A_HPP, 32'h000003FF);
    chk_rd(`VCPA_A_AIA, 32'h000003FF);
    chk_rd(`VCPA_A_STS, 32'h00000002);
    // Reserved bits of the binary point drop on write
    wr_ok(`VCPA_A_ABP, 32'hFFFFFFFF);
    chk_rd(`VCPA_A_ABP, 32'h00000007);
    rd(8'h1C, q, r);
    `CHK(r, `VCPA_RESP_SLVERR)
    `CHK(q, 32'h00000000)
    wr(8'h1C, 32'hFFFFFFFF, 4'hF, r);
    `CHK(r, `VCPA_RESP_SLVERR)
    wr_ok(`VCPA_A_HPP, 32'h00000123);
    chk_rd(`VCPA_A_HPP, 32'h000003FF);
    wr(`VCPA_A_APR, 32'hFFFFFFFF, 4'h1, r);
    chk_rd(`VCPA_A_APR, 32'h000000FF);
    for (int n = 0; n < 300; n++) begin
      // every pending candidate is held in an entry
      for (int i = 0; i < 4; i++) begin
        le[i] = {$urandom % 2 == 1, $urandom % 2 == 1, 2'($urandom % 4),
                 7'h0, 5'($urandom % 8), 3'h0, 3'($urandom), 10'($urandom % 1020)};
        wr_ok(8'(`VCPA_A_LE0 + 4 * i), le[i]);
      end
      apr = ($urandom % 3 == 0) ? 32'h0 : 32'h1 << ($urandom % 8);
      acknowledge_control = 1'($urandom);
      msk = 2'($urandom);
      wr_ok(`VCPA_A_APR, apr);
      wr_ok(`VCPA_A_CTL, {31'h0, acknowledge_control});
      wr_ok(`VCPA_A_MSK, {30'h0, msk});
      `CHK(irq, 1'b0)
      q = exp_query();
      chk_rd(`VCPA_A_HPP, q);
      chk_rd(`VCPA_A_HPP, q);
      e = ack_model();
      chk_rd(`VCPA_A_AIA, e);
      for (int i = 0; i < 4; i++)
        chk_rd(8'(`VCPA_A_LE0 + 4 * i), le[i]);
      chk_rd(`VCPA_A_APR, apr);
      chk_rd(`VCPA_A_CTL, {31'h0, acknowledge_control});
      `CHK(irq, |(sts & msk))
      chk_rd(`VCPA_A_STS, {30'h0, sts});
      sts = 2'h0;
      chk_rd(`VCPA_A_STS, 32'h00000000);
    end
    final_report();
  end
endmodule
